// ==== hw/cmd_decoder.sv ====
// Purpose: Command byte decoder at the front of the serial register port
// Assumes: Link clock, select and data in arrive from pins; host shifts MSB first
//          Host holds select low across a command and its data
// Notes:   Data bits of the following transfer are passed out with a target select
//          A deselect at any point drops back to the command phase
//          Every pin reaches the logic through two flops, so an output
//          follows its pin edge by three system clock edges
//          The link clock must stay high and low for more than one
//          system clock period each, or rises are missed
//
// Behaviour
// - First byte of every transaction is command
// - Command selects next transfer target and direction
// - Start transaction only when gate bit zero
// - Direction bit: zero write, one read
// - Low six bits decode the target register
// - Codes 100000-100011 select setup registers 0-3
// - Codes 101000-101011 select filter registers 0-3
// - Command word write-only at code zero, reset zero
`timescale 1ns/10ps
`default_nettype none

module cmd_decoder
  import cmd_decoder_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Serial link pins
  input  wire logic        link_sclk,
  input  wire logic        link_cs_n,
  input  wire logic        link_din,
  // Decoded transfer towards the register bank
  output logic             xfer_active,
  output logic             xfer_read,
  output logic [5:0]       target_register_code,
  output logic [4:0]       xfer_len,
  output logic             data_bit_valid,
  output logic             data_bit,
  output logic             xfer_done,
  output logic             cmd_rejected,
  output logic [7:0]       command_word
);

  // Waiting for a command, passing data bits, or ignoring a refused frame
  typedef enum {ST_CMD, ST_XFER, ST_SKIP} state_e;

  // Pin synchronisers, two flops each; bit 2 link clock, bit 1 select, bit 0 data
  // Preset to the idle pin levels so that release of reset shows no false
  // link clock rise and no false select
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic       sclk_prev_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q      <= 3'h7;
      sync_q      <= 3'h7;
      sclk_prev_q <= 1'b1;
    end else begin
      meta_q      <= {link_sclk, link_cs_n, link_din};
      sync_q      <= meta_q;
      sclk_prev_q <= sync_q[2];
    end
  end

  // Link clock rise and settled select and data; only the second flop is read
  logic sclk_rise;
  logic cs_n_s;
  logic din_s;
  assign sclk_rise = sync_q[2] & ~sclk_prev_q;
  assign cs_n_s    = sync_q[1];
  assign din_s     = sync_q[0];

  // Target decode and transfer length; zero length marks an unlisted code
  // Codes in the gaps of the map give zero, so a stray command is refused
  // rather than routed to a neighbouring register
  function automatic logic [4:0] code_len(input logic [5:0] c);
    logic [4:0] l;
    l = 5'h00;
    unique case (c)
      CODE_STATUS:   l = LEN_8;
      CODE_ADC_MODE: l = LEN_16;
      CODE_IF_MODE:  l = LEN_16;
      CODE_REG_CHK:  l = LEN_24;
      CODE_DATA:     l = LEN_24;
      CODE_GPIO:     l = LEN_16;
      CODE_ID:       l = LEN_16;
      default: begin
        if (c[5:2] == GRP_CHANNEL) l = LEN_16;
        else if (c[5:2] == GRP_SETUP) l = LEN_16;
        else if (c[5:2] == GRP_FILTER) l = LEN_16;
        else if (c[5:2] == GRP_OFFSET) l = LEN_24;
        else if (c[5:2] == GRP_GAIN) l = LEN_24;
      end
    endcase
    return l;
  endfunction

  // Decoder state
  // bit_cnt counts command bits, left counts data bits still to come;
  // cmd holds the last accepted command and stands through its transfer
  state_e     state_q;
  state_e     state_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [4:0] left_q;
  logic [4:0] left_d;
  logic [7:0] cmd_q;
  logic [7:0] cmd_d;
  logic       active_q;
  logic       active_d;
  logic       dvalid_q;
  logic       dvalid_d;
  logic       dbit_q;
  logic       dbit_d;
  logic       done_q;
  logic       done_d;
  logic       rej_q;
  logic       rej_d;
  // Combinational helpers
  logic [7:0] next_byte;
  logic [4:0] len;

  // Next state: one step per synchronised link clock rise while selected
  // Pulses default low so each stands for exactly one system clock
  always_comb begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    left_d    = left_q;
    cmd_d     = cmd_q;
    active_d  = active_q;
    dvalid_d  = 1'b0;
    dbit_d    = dbit_q;
    done_d    = 1'b0;
    rej_d     = 1'b0;
    next_byte = {shift_q[6:0], din_s};
    len       = code_len(next_byte[5:0]);
    if (cs_n_s) begin
      // Deselect aborts any transfer and rearms the command phase
      // Shift contents are left; eight fresh bits overwrite them
      state_d   = ST_CMD;
      bit_cnt_d = 3'h0;
      active_d  = 1'b0;
    end else if (sclk_rise) begin
      unique case (state_q)
        ST_CMD: begin
          // Eighth bit completes the byte; gate and code decide its fate
          shift_d   = next_byte;
          bit_cnt_d = bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            if (next_byte[GATE_BIT] || (len == 5'h00)) begin
              rej_d   = 1'b1;
              state_d = ST_SKIP;
            end else begin
              cmd_d    = next_byte;
              left_d   = len;
              active_d = 1'b1;
              state_d  = ST_XFER;
            end
          end
        end
        ST_XFER: begin
          // Each rise hands one data bit to the register bank
          dvalid_d = 1'b1;
          dbit_d   = din_s;
          left_d   = left_q - 5'h01;
          // Last data bit closes the transfer; the next bit is a command
          if (left_q == 5'h01) begin
            done_d    = 1'b1;
            active_d  = 1'b0;
            bit_cnt_d = 3'h0;
            state_d   = ST_CMD;
          end
        end
        ST_SKIP: begin
          // Clocks after a refused command are ignored until deselect
          state_d = ST_SKIP;
        end
      endcase
    end
  end

  // Decoder registers
  // Reset clears the command word, so direction reads write and code reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q   <= ST_CMD;
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
      left_q    <= 5'h00;
      cmd_q     <= CMD_WORD_RESET;
      active_q  <= 1'b0;
      dvalid_q  <= 1'b0;
      dbit_q    <= 1'b0;
      done_q    <= 1'b0;
      rej_q     <= 1'b0;
    end else begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      left_q    <= left_d;
      cmd_q     <= cmd_d;
      active_q  <= active_d;
      dvalid_q  <= dvalid_d;
      dbit_q    <= dbit_d;
      done_q    <= done_d;
      rej_q     <= rej_d;
    end
  end

  // Outputs straight from flops
  // Direction and code come from the held command, so they stand until replaced
  assign xfer_active          = active_q;
  assign xfer_read            = cmd_q[DIR_BIT];
  assign target_register_code = cmd_q[CODE_W-1:0];
  assign xfer_len             = left_q;
  assign data_bit_valid       = dvalid_q;
  assign data_bit             = dbit_q;
  assign xfer_done            = done_q;
  assign cmd_rejected         = rej_q;
  assign command_word         = cmd_q;

endmodule

`default_nettype wire

// ==== hw/cmd_decoder_pkg.sv ====
// Purpose: Constants for the serial register command decoder
// Assumes: Eight-bit command byte, MSB first on the serial link
// Notes:   Target codes are the six low command bits
package cmd_decoder_pkg;

  localparam int unsigned CMD_W           = 8;
  localparam int unsigned GATE_BIT        = 7;
  localparam int unsigned DIR_BIT         = 6;
  localparam int unsigned CODE_W          = 6;
  localparam logic [7:0]  CMD_WORD_OFFSET = 8'h00;
  localparam logic [7:0]  CMD_WORD_RESET  = 8'h00;

  // Target codes
  localparam logic [5:0] CODE_STATUS   = 6'h00;
  localparam logic [5:0] CODE_ADC_MODE = 6'h01;
  localparam logic [5:0] CODE_IF_MODE  = 6'h02;
  localparam logic [5:0] CODE_REG_CHK  = 6'h03;
  localparam logic [5:0] CODE_DATA     = 6'h04;
  localparam logic [5:0] CODE_GPIO     = 6'h06;
  localparam logic [5:0] CODE_ID       = 6'h07;
  localparam logic [3:0] GRP_CHANNEL   = 4'h4;
  localparam logic [3:0] GRP_SETUP     = 4'h8;
  localparam logic [3:0] GRP_FILTER    = 4'ha;
  localparam logic [3:0] GRP_OFFSET    = 4'hc;
  localparam logic [3:0] GRP_GAIN      = 4'he;

  // Transfer lengths in bits, per target
  localparam logic [4:0] LEN_8  = 5'h08;
  localparam logic [4:0] LEN_16 = 5'h10;
  localparam logic [4:0] LEN_24 = 5'h18;

endpackage

// ==== verification/cmd_decoder_asserts.sv ====
// Purpose: Port checks for the command decoder
// Assumes: Outputs follow the pins within a few cycles
// Notes:   Bound to every decoder instance
`timescale 1ns/10ps
`default_nettype none
module cmd_decoder_checker
  import cmd_decoder_pkg::*;
(
  // Clock, reset, select
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       link_cs_n,
  // Decoded transfer
  input wire logic       xfer_active,
  input wire logic       xfer_read,
  input wire logic       xfer_done,
  input wire logic       cmd_rejected,
  input wire logic [5:0] target_register_code,
  input wire logic [4:0] xfer_len,
  input wire logic [7:0] command_word
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Live transfer against the accepted command
  gate_clear_a: assert property ($rose(xfer_active) |-> !command_word[7]) else $error("gate");
  read_dir_a: assert property (xfer_active |=> $stable(xfer_read)) else $error("dir");
  code_sel_a:
    assert property (xfer_active |=> $stable(target_register_code)) else $error("code");
  status_len_a:
    assert property ($rose(xfer_active) && target_register_code == CODE_STATUS
      |-> xfer_len == LEN_8) else $error("len");
  bank_code_a:
    assert property ($rose(xfer_active) && target_register_code[5:4] == 2'h2
      |-> !target_register_code[2] && xfer_len == LEN_16) else $error("bank");
  trim_len_a:
    assert property ($rose(xfer_active) && target_register_code[5:4] == 2'h3
      |-> !target_register_code[2] && xfer_len == LEN_24) else $error("trim");
  // Return to command phase; a refused command opens no transfer
  done_idle_a: assert property (xfer_done |=> !xfer_active) else $error("done");
  reject_hold_a: assert property (cmd_rejected |-> !xfer_active [*8]) else $error("reject");
  reject_keep_a: assert property (cmd_rejected |-> $stable(command_word)) else $error("keep");
  cs_abort_a: assert property ($rose(link_cs_n) |-> ##[0:6] !xfer_active) else $error("abort");
  // Main scenarios
  read_cov: cover property ($rose(xfer_active) && xfer_read);
  done_cov: cover property (xfer_done);
  reject_cov: cover property (cmd_rejected);
endmodule
bind cmd_decoder cmd_decoder_checker chk_i (
  .sys_clk              (sys_clk),
  .rst                  (rst),
  .link_cs_n            (link_cs_n),
  .xfer_active          (xfer_active),
  .xfer_read            (xfer_read),
  .xfer_done            (xfer_done),
  .cmd_rejected         (cmd_rejected),
  .target_register_code (target_register_code),
  .xfer_len             (xfer_len),
  .command_word         (command_word)
);
`default_nettype wire

// ==== verification/link_host.sv ====
// Purpose: Host end of the serial link
// Assumes: 200 ns link clock, idle high between frames
// Notes:   Data changes on falling edges
`timescale 1ns/10ps
`default_nettype none
module link_host (
  // Link pins
  output var logic link_sclk,
  output var logic link_cs_n,
  output var logic link_din
);
  initial {link_sclk, link_cs_n, link_din} = 3'h6;
  // Select and shift n bits MSB first
  // Pins change by non-blocking assignment, so a change that lands on a
  // system clock edge is seen only after that edge
  task automatic shift(input logic [31:0] v, input int n);
    link_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      #100 link_sclk <= 1'b0;
      link_din <= v[i];
      #100 link_sclk <= 1'b1;
    end
  endtask
  // Deselect; released data shows the inverse
  task automatic stop();
    #100 link_cs_n <= 1'b1;
    link_din <= ~link_din;
  endtask
endmodule
`default_nettype wire

// ==== verification/register_access_command_decoder_tb.sv ====
// Purpose: Self-checking bench for the command decoder
// Assumes: Host model drives the link pins
// Notes:   Every command byte is tried once in the table, five of them again afterwards
`timescale 1ns/10ps
`default_nettype none
module register_access_command_decoder_tb;
  import cmd_decoder_pkg::*;
  logic        sys_clk, sclk, cs_n, din, act, rd, dv, db, done, rej;
  logic        rst = 1'b1;
  logic [5:0]  code;
  logic [4:0]  len;
  logic [7:0]  cw;
  logic [31:0] sh = 32'h0;
  logic [4:0]  rows [256];
  int          errors, num_checks, nrej, nbit, ndone;
  int          keep_rej;
  link_host host (.link_sclk(sclk), .link_cs_n(cs_n), .link_din(din));
  cmd_decoder dut (.sys_clk(sys_clk), .rst(rst), .link_sclk(sclk), .link_cs_n(cs_n), .link_din(din),
    .xfer_active(act), .xfer_read(rd), .target_register_code(code), .xfer_len(len), .data_bit_valid(dv),
    .data_bit(db), .xfer_done(done), .cmd_rejected(rej), .command_word(cw));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Count pulses and gather data bits
  always @(posedge sys_clk) begin
    if (rej === 1'b1) nrej <= nrej + 1;
    if (done === 1'b1) ndone <= ndone + 1;
    if (dv === 1'b1) nbit <= nbit + 1;
    if (dv === 1'b1) sh <= {sh[30:0], db};
  end
  // Expected transfer length, zero when refused
  function automatic logic [4:0] exp_len(input logic [7:0] c);
    if (c[7]) return 5'h00;
    case (c[5:0]) inside
      6'h00: return LEN_8;
      6'h01, 6'h02, 6'h06, 6'h07, [6'h10:6'h13], [6'h20:6'h23], [6'h28:6'h2b]: return LEN_16;
      6'h03, 6'h04, [6'h30:6'h33], [6'h38:6'h3b]: return LEN_24;
      default: return 5'h00;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, s);
    end
  endtask
  // One command then its data, select kept low
  task automatic run(input logic [7:0] c, input logic [4:0] n);
    int r0, b0, d0;
    r0 = nrej;
    b0 = nbit;
    d0 = ndone;
    host.shift({24'h0, c}, 8);
    repeat (6) @(posedge sys_clk);
    chk("reject", r0 + (n == 0), nrej);
    chk("active", n != 0, act);
    if (n != 0) begin
      chk("cmd", {c, c[6:0], n}, {cw, rd, code, len});
      host.shift(32'h00c35a96, n);
      repeat (6) @(posedge sys_clk);
      chk("data", 32'h00c35a96 & ~(32'hffffffff << n), sh & ~(32'hffffffff << n));
      chk("bits", b0 + n, nbit);
      chk("done", d0 + 1, ndone);
      chk("idle", 32'h0, act);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("reset", 32'h0, {act, cw});
    for (int i = 0; i < 256; i++) rows[i] = exp_len(8'(i));
    foreach (rows[i]) begin
      run(8'(i), rows[i]);
      host.stop();
      repeat (8) @(posedge sys_clk);
    end
    $display("table done");
    // Two transfers in one select, an aborted byte, then a fresh one
    run(8'h47, LEN_16);
    run(8'h00, LEN_8);
    keep_rej = nrej;
    host.shift(32'h5, 4);
    host.stop();
    repeat (8) @(posedge sys_clk);
    chk("abort_rej", keep_rej, nrej);
    chk("abort_act", 32'h0, act);
    run(8'h68, LEN_16);
    host.stop();
    repeat (8) @(posedge sys_clk);
    $display("back to back done");
    // Reset while a transfer is open
    host.shift(32'h10, 8);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("midreset", 32'h0, {act, cw});
    rst <= 1'b0;
    host.stop();
    repeat (8) @(posedge sys_clk);
    run(8'h01, LEN_16);
    host.stop();
    repeat (8) @(posedge sys_clk);
    $display("reset done");
    report_and_stop();
  end
  // Watchdog
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
